//--- serial_port_mux_consts.vh
// Constants for the second serial port management mux.
// Assumes a 10 MHz clock and byte-wide receive streams.
`ifndef SERIAL_PORT_MUX_CONSTS_VH
`define SERIAL_PORT_MUX_CONSTS_VH

// ==========================================
// Register map (AXI4-Lite byte addresses)
`define REG_CONTROL      4'h0
`define REG_STATUS       4'h4
`define REG_PASSWORD     4'h8
`define REG_CMDFILTER    4'hC

// ==========================================
// Control fields
`define CTL_MODE_LSB     0
`define CTL_RESTRICT_BIT 2
`define CTL_PWEN_BIT     3
`define CTL_SWCLAIM_BIT  4
`define CTL_BOOTDIS_BIT  5
`define CTL_LOCAL_BIT    6
`define CTL_RESET        32'h00000000

// ==========================================
// Access modes
`define MODE_DISABLED    2'h0
`define MODE_PREBOOT     2'h1
`define MODE_ALWAYS      2'h2
`define MODE_SWACT       2'h3

// ==========================================
// Owners
`define OWN_HOST         2'h0
`define OWN_MGMT         2'h1
`define OWN_REDIR        2'h2

// ==========================================
// Escape sequence and command classes
`define ESC_BYTE0        8'h1B
`define ESC_BYTE1        8'h4F
`define ESC_BYTE2        8'h39
`define CMD_POWER_DOWN   8'h02
`define CMD_NMI          8'h03
`define CMD_RESET        8'h04
`define CMD_SET_PASSWORD 8'h05

// ==========================================
// Timing
`define CLK_HZ           10000000
`define IDLE_TIMEOUT_S   30
`define LINE_BAUD        19200

`endif

//--- serial_port_mgmt_mux.v
// Arbitration of the second serial port between host serial controller,
// console redirection and the management controller's emergency port.
// Assumes byte streams already framed by UARTs; line bits enter on other clock.
// How it works
// - Disabled mode keeps port on host forever
// - Pre-boot mode serves management, or redirection during self-test, until boot disable
// - Always-active keeps management attached, hides port
// - Restricted blocks power-down, NMI, reset commands
// - Restricted still passes other commands except set-password, and redirection
// - Software mode may claim or release once boot disable is set
// - Management ownership denies redirection and software
// - Redirection ownership denies management; normal means host
// - Password gate discards commands until accepted
// - Switch to management clears password acceptance
// - Idle over thirty seconds revokes acceptance
// - Password changes only via local setup path
// - Escape O 9 switches mux to management
// - After escape, host controller data ignored
// - Self-test watchdog timeout moves port over
// - Shared port uses fixed 19200 N81 XonXoff
// - Except in disabled mode, management owns port until self-test begins
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_mux_consts.vh"

module serial_port_mgmt_mux #(
	parameter         CLK_HZ    = `CLK_HZ,
	parameter [31:0]  IDLE_CYCLES = `IDLE_TIMEOUT_S * `CLK_HZ
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        clkEn,
	// AXI4-Lite slave
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// System state
	input  wire        selfTestActive,
	input  wire        systemOff,
	input  wire        watchdogTimeout,
	// Line pins
	input  wire        lineRxd,
	output reg         lineTxd,
	input  wire        hostTxd,
	output reg         hostRxd,
	input  wire        mgmtTxd,
	output reg         mgmtRxd,
	output reg         portVisibleToOs,
	output reg         modemToMgmt,
	output reg         lineFixedFormat,
	// Received remote byte stream
	input  wire [7:0]  rxByte,
	input  wire        rxValid,
	// Accepted command stream to management controller
	output reg  [7:0]  cmdByte,
	output wire        cmdValid,
	input  wire        cmdReady,
	output wire        rxStall
);

	// ==========================================
	// Pin synchronisers
	reg [2:0] syncA;
	reg [2:0] syncB;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			syncA <= 3'h0;
			syncB <= 3'h0;
		end else if (clkEn) begin
			syncA <= {mgmtTxd, hostTxd, lineRxd};
			syncB <= syncA;
		end
	end

	// ==========================================
	// Register file
	reg [31:0] control;
	reg [31:0] password;
	reg [1:0]  owner;
	reg        pwAccepted;
	reg        escSeen;
	reg        booted;
	reg        selfTestSeen;
	reg [31:0] idleCount;
	reg [7:0]  dropCount;

	wire [1:0] mode     = control[`CTL_MODE_LSB+1:`CTL_MODE_LSB];
	wire       restrictOn = control[`CTL_RESTRICT_BIT];
	wire       pwEnable = control[`CTL_PWEN_BIT];
	wire       swClaim  = control[`CTL_SWCLAIM_BIT];
	wire       bootDis  = control[`CTL_BOOTDIS_BIT];
	wire       localSet = control[`CTL_LOCAL_BIT];

	reg        awHeld;
	reg        wHeld;
	reg [3:0]  awAddr;
	reg [31:0] wData;
	reg [3:0]  wStrb;
	wire       doWrite = awHeld && wHeld && !s_axi_bvalid;

	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// Byte-lane merge used by both writable registers
	function [31:0] mergeLanes;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer i;
		begin
			mergeLanes = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					mergeLanes[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction

	// Write channel: address and data may come in either order
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld       <= 1'b0;
			wHeld        <= 1'b0;
			awAddr       <= 4'h0;
			wData        <= 32'h00000000;
			wStrb        <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			control      <= `CTL_RESET;
			password     <= 32'h00000000;
		end else if (clkEn) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld       <= 1'b0;
				wHeld        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'h0;
				case (awAddr)
				`REG_CONTROL: control <= mergeLanes(control, wData, wStrb);
				`REG_PASSWORD: begin
					if (localSet)
						password <= mergeLanes(password, wData, wStrb);
					else
						s_axi_bresp <= 2'h2;
				end
				`REG_STATUS, `REG_CMDFILTER: s_axi_bresp <= 2'h0;
				default: s_axi_bresp <= 2'h2;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'h0;
		end else if (clkEn) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				case (s_axi_araddr)
				`REG_CONTROL:   s_axi_rdata <= control;
				`REG_STATUS:    s_axi_rdata <= {24'h000000, booted, selfTestSeen,
				                                escSeen, pwAccepted, 2'h0, owner};
				`REG_PASSWORD:  s_axi_rdata <= 32'h00000000; // Never readable
				`REG_CMDFILTER: s_axi_rdata <= {24'h000000, dropCount};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// Escape detector
	reg [1:0] escState;
	wire      byteIn = rxValid && !rxStall;
	wire      escHit = byteIn && escState == 2'h2 && rxByte == `ESC_BYTE2;

	// Any byte off the sequence restarts the match
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			escState <= 2'h0;
		end else if (clkEn && byteIn) begin
			case (escState)
			2'h0: escState <= (rxByte == `ESC_BYTE0) ? 2'h1 : 2'h0;
			2'h1: escState <= (rxByte == `ESC_BYTE1) ? 2'h2 :
			                  (rxByte == `ESC_BYTE0) ? 2'h1 : 2'h0;
			2'h2: escState <= (rxByte == `ESC_BYTE0) ? 2'h1 : 2'h0;
			default: escState <= 2'h0;
			endcase
		end
	end

	// ==========================================
	// Ownership
	reg [1:0] next_owner;
	always @* begin
		next_owner = owner;
		if (mode == `MODE_DISABLED) begin
			next_owner = `OWN_HOST;
		end else if (!selfTestSeen || watchdogTimeout || escSeen) begin
			next_owner = `OWN_MGMT;
		end else if (mode == `MODE_ALWAYS) begin
			next_owner = `OWN_MGMT;
		end else if (mode == `MODE_SWACT && booted) begin
			next_owner = swClaim ? `OWN_MGMT : `OWN_HOST;
		end else if (systemOff) begin
			next_owner = `OWN_MGMT;
		end else if (!booted) begin
			next_owner = selfTestActive ? `OWN_REDIR : `OWN_MGMT;
		end else begin
			next_owner = `OWN_HOST;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			owner        <= `OWN_MGMT;
			selfTestSeen <= 1'b0;
			booted       <= 1'b0;
			escSeen      <= 1'b0;
		end else if (clkEn) begin
			owner <= next_owner;
			if (selfTestActive)
				selfTestSeen <= 1'b1;
			booted <= bootDis;
			if (escHit && owner == `OWN_REDIR)
				escSeen <= 1'b1;
			else if (systemOff)
				escSeen <= 1'b0;
		end
	end

	// ==========================================
	// Password gate and idle timer
	wire toMgmt  = next_owner == `OWN_MGMT && owner != `OWN_MGMT;
	wire mgmtIn  = byteIn && owner == `OWN_MGMT;
	wire pwMatch = rxByte == password[7:0];
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pwAccepted <= 1'b0;
			idleCount  <= 32'h00000000;
		end else if (clkEn) begin
			if (mgmtIn)
				idleCount <= 32'h00000000;
			else if (idleCount <= IDLE_CYCLES)
				idleCount <= idleCount + 32'h00000001;
			// A fresh byte after a long idle must still be able to log in
			if (toMgmt || (idleCount > IDLE_CYCLES && !mgmtIn))
				pwAccepted <= 1'b0;
			else if (mgmtIn && pwMatch)
				pwAccepted <= 1'b1;
		end
	end

	// ==========================================
	// Command filter into a two-entry buffer
	wire blocked = rxByte == `CMD_POWER_DOWN || rxByte == `CMD_NMI ||
	               rxByte == `CMD_RESET;
	wire gateOk  = !pwEnable || pwAccepted;
	wire pass    = mgmtIn && gateOk && !(restrictOn && blocked) &&
	               rxByte != `CMD_SET_PASSWORD;

	reg [7:0] buf0;
	reg [7:0] buf1;
	reg [1:0] fill;
	wire      pop = cmdValid && cmdReady;
	assign cmdValid = fill != 2'h0;
	assign rxStall  = fill == 2'h2;

	// Full buffer stalls the receive source so no word is lost
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			buf0      <= 8'h00;
			buf1      <= 8'h00;
			fill      <= 2'h0;
			dropCount <= 8'h00;
		end else if (clkEn) begin
			if (pop) begin
				buf0 <= (pass && fill == 2'h1) ? rxByte : buf1;
				if (pass && fill == 2'h2)
					buf1 <= rxByte;
				fill <= pass ? fill : fill - 2'h1;
			end else if (pass) begin
				if (fill == 2'h0)
					buf0 <= rxByte;
				else
					buf1 <= rxByte;
				fill <= fill + 2'h1;
			end
			if (mgmtIn && !pass)
				dropCount <= dropCount + 8'h01;
		end
	end

	always @* cmdByte = buf0;

	// ==========================================
	// Line routing
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			lineTxd         <= 1'b1;
			hostRxd         <= 1'b1;
			mgmtRxd         <= 1'b1;
			portVisibleToOs <= 1'b0;
			modemToMgmt     <= 1'b1;
			lineFixedFormat <= 1'b0;
		end else if (clkEn) begin
			lineTxd <= (owner == `OWN_MGMT) ? syncB[2] : syncB[1];
			hostRxd <= (owner == `OWN_MGMT) ? 1'b1 : syncB[0];
			mgmtRxd <= (owner == `OWN_MGMT) ? syncB[0] : 1'b1;
			portVisibleToOs <= mode != `MODE_ALWAYS && owner == `OWN_HOST;
			modemToMgmt     <= owner == `OWN_MGMT;
			lineFixedFormat <= mode != `MODE_DISABLED;
		end
	end

endmodule
`default_nettype wire

//--- serial_port_mux_chk.sv
// Checker on the mux top ports: bus answers, stream hold, ownership.
// Assumes one clock and a reset that is high while asserted.
`timescale 1ns/1ps
`default_nettype none
module serial_port_mux_chk (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       cmdValid,
	input wire logic       cmdReady,
	input wire logic [7:0] cmdByte,
	input wire logic       rxStall,
	input wire logic       watchdogTimeout,
	input wire logic       modemToMgmt,
	input wire logic       portVisibleToOs
);
	// ==========
	// One domain; reset disables every check
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	AST_RST_MGMT: assert property ($past(rst) |-> modemToMgmt && !portVisibleToOs)
		else $error("port not with management after reset");
	AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	AST_CMD_HOLD: assert property (cmdValid && !cmdReady |=> cmdValid && $stable(cmdByte))
		else $error("command lost under stall");
	AST_STALL: assert property (rxStall && !cmdReady |=> rxStall)
		else $error("stall dropped while full");
	AST_WD: assert property (watchdogTimeout [*4] |-> modemToMgmt)
		else $error("watchdog did not move port");
	AST_HIDE: assert property (modemToMgmt [*2] |-> !portVisibleToOs)
		else $error("port visible while management owns it");
endmodule
`default_nettype wire

//--- remote_terminal.sv
// Remote terminal model feeding received bytes to the mux stream.
// Assumes each send is started by the bench after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module remote_terminal (
	input  wire logic       clk,
	input  wire logic       rxStall,
	output var  logic [7:0] rxByte,
	output var  logic       rxValid,
	output var  logic       lineRxd
);
	// ==========
	// Idle line rests at mark, fixed 19200 8N1 framing assumed
	initial begin
		rxByte = 8'hFF;
		rxValid = 1'h0;
		lineRxd = 1'h1;
	end

	// Offer a byte and hold it until the mux takes it
	task send(input logic [7:0] b);
		@(posedge clk);
		rxByte <= b;
		rxValid <= 1'h1;
		do @(posedge clk); while (rxStall);
		rxValid <= 1'h0;
		rxByte <= ~b; // Stale data must not look reusable
	endtask
endmodule
`default_nettype wire

//--- tb.sv
// Testbench for the serial port mux: bus tasks, one task per case.
// Assumes the remote terminal model drives the receive stream.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_mux_consts.vh"
module tb;
	localparam [31:0] SWSEQ = 32'h21233323;
	localparam [7:0]  SWOWN = 8'h04;
	logic        clk, rst, clkEn, systemOff, selfTestActive, watchdogTimeout;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        lineRxd, lineTxd, hostTxd, hostRxd, mgmtTxd, mgmtRxd, lineFixedFormat;
	logic        portVisibleToOs, modemToMgmt, rxValid, cmdValid, cmdReady, rxStall;
	logic [7:0]  rxByte, cmdByte, q[$];
	int          fails, n_checks, k;

	// Short idle limit keeps the revocation case brief
	serial_port_mgmt_mux #(.IDLE_CYCLES(32'h32)) i_serial_port_mgmt_mux (.*);
	remote_terminal i_remote_terminal (.clk, .rxStall, .rxByte, .rxValid, .lineRxd);

	// ==========
	// Clock of 100 ns
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	// Collect bytes handed to the management side
	always @(posedge clk) begin
		if (cmdValid && cmdReady)
			q.push_back(cmdByte);
	end

	task chk(input [31:0] got, input [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task summarize;
		$display("fails=%0d n_checks=%0d", fails, n_checks);
		if (fails == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========
	// Bus tasks: hold each channel until taken
	task wr(input [3:0] a, input [31:0] d, input [1:0] e);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, e);
	endtask

	task rd(input [3:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		rv = s_axi_rdata;
	endtask

	task own(input [1:0] e);
		rd(`REG_STATUS);
		chk(rv[1:0], e);
	endtask

	// Bytes leave most significant first
	task sendn(input [31:0] w, input int n);
		for (k = n - 1; k >= 0; k--)
			i_remote_terminal.send(w[8*k+:8]);
	endtask

	task do_rst;
		rst <= 1'h1;
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		q.delete();
	endtask

	task post;
		selfTestActive <= 1'h1;
		repeat (5) @(posedge clk);
		selfTestActive <= 1'h0;
		repeat (3) @(posedge clk);
	endtask

	task redir;
		do_rst;
		wr(`REG_CONTROL, 32'h1, 2'h0);
		selfTestActive <= 1'h1;
		repeat (4) @(posedge clk);
		own(`OWN_REDIR);
	endtask

	// ==========
	// Cases
	task t_boot;
		do_rst;
		chk(modemToMgmt, 1'h1);
		chk(lineTxd, 1'h1);
		rd(`REG_CONTROL);
		chk(rv, `CTL_RESET);
		own(`OWN_HOST);
		wr(`REG_CONTROL, 32'h1, 2'h0);
		own(`OWN_MGMT);
		chk(lineFixedFormat, 1'h1);
	endtask

	task t_off;
		do_rst;
		post;
		own(`OWN_HOST);
		chk(portVisibleToOs, 1'h1);
		chk(modemToMgmt, 1'h0);
		chk(lineFixedFormat, 1'h0);
	endtask

	// Blocked codes dropped; a full buffer stalls and loses nothing
	task t_restr;
		do_rst;
		wr(`REG_CONTROL, 32'h6, 2'h0);
		sendn(32'h02030405, 4);
		sendn(32'h010A, 2);
		chk(portVisibleToOs, 1'h0);
		rd(`REG_CMDFILTER);
		chk(rv[7:0], 8'h4);
		cmdReady <= 1'h0;
		sendn(32'h1112, 2);
		repeat (2) @(posedge clk);
		chk(rxStall, 1'h1);
		cmdReady <= 1'h1;
		repeat (4) @(posedge clk);
		chk({q[0], q[1], q[2], q[3]}, 32'h010A1112);
	endtask

	task t_pw;
		do_rst;
		wr(`REG_CONTROL, 32'hA, 2'h0);
		wr(`REG_PASSWORD, 32'h5A, 2'h2);
		wr(`REG_CONTROL, 32'h4A, 2'h0);
		wr(`REG_PASSWORD, 32'h5A, 2'h0);
		sendn(32'h215A22, 3);
		rd(`REG_STATUS);
		chk(rv[4], 1'h1);
		repeat (60) @(posedge clk);
		sendn(32'h23, 1);
		rd(`REG_STATUS);
		chk(rv[4], 1'h0);
		chk(q.size(), 32'h1);
		chk(q[0], 8'h22);
	endtask

	// Broken escape first, then the real one; host data ignored after
	task t_esc;
		redir;
		sendn(32'h1B4F4139, 4);
		own(`OWN_REDIR);
		sendn(32'h1B4F39, 3);
		own(`OWN_MGMT);
		{hostTxd, mgmtTxd} <= 2'h1;
		repeat (5) @(posedge clk);
		chk(lineTxd, 1'h1);
		{hostTxd, mgmtTxd} <= 2'h2;
		repeat (5) @(posedge clk);
		chk(lineTxd, 1'h0);
		chk(hostRxd, 1'h1);
		{hostTxd, mgmtTxd, selfTestActive} <= 3'h6;
		systemOff <= 1'h1;
		repeat (3) @(posedge clk);
		own(`OWN_MGMT);
		chk(rv[5], 1'h0);
		systemOff <= 1'h0;
	endtask

	task t_wd;
		redir;
		watchdogTimeout <= 1'h1;
		repeat (6) @(posedge clk);
		own(`OWN_MGMT);
		{watchdogTimeout, selfTestActive} <= 2'h0;
	endtask

	task t_sw;
		do_rst;
		post;
		for (k = 0; k < 4; k++) begin
			wr(`REG_CONTROL, {24'h0, SWSEQ[31-8*k-:8]}, 2'h0);
			own(SWOWN[7-2*k-:2]);
		end
	endtask

	// Defaults at time zero, then the cases in turn
	initial begin
		{rst, clkEn, systemOff, selfTestActive, watchdogTimeout} = 5'h18;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
		s_axi_wstrb = 4'hF;
		{hostTxd, mgmtTxd, cmdReady} = 3'h7;
		{fails, n_checks} = 64'h0;
		t_boot;
		t_off;
		t_restr;
		t_pw;
		t_esc;
		t_wd;
		t_sw;
		summarize;
	end

	// Hang guard, far beyond the expected run
	initial begin
		#2000000;
		fails++;
		summarize;
	end
endmodule

bind serial_port_mgmt_mux serial_port_mux_chk i_serial_port_mux_chk (.*);
`default_nettype wire
